// *** hw/pad_mux_pkg.sv ***
// Purpose: Constants for the clock and address pad multiplexer.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets, field positions and control register reset values are declared here; pad and strap flop resets sit in the module.
package pad_mux_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CLKOUT_SEL = 8'h00;  // clock_out_select_reg
  localparam logic [7:0] OFS_BUS_CTRL   = 8'h04;  // bus_control_reg
  localparam logic [7:0] OFS_PORT_PER   = 8'h08;  // port_a_peripheral_enable
  localparam logic [7:0] OFS_PORT_DDR   = 8'h0c;  // direction, 1 = output
  localparam logic [7:0] OFS_PORT_DOUT  = 8'h10;  // port output data
  localparam logic [7:0] OFS_PORT_PUR   = 8'h14;  // port_a_pullup_reg
  localparam logic [7:0] OFS_PORT_DIN   = 8'h18;  // pad levels, read only
  localparam logic [7:0] OFS_STATUS     = 8'h1c;  // strap and bus state

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int PAD_LSB        = 8;    // Pads sit at port bits 8..13
  localparam int PAD_N          = 6;
  localparam int BUS_DRIVE_BIT  = 0;    // bus_drive_hold in bus_control_reg
  localparam int PLL_REF_BIT    = 1;    // 1 = input clock feeds PLL
  localparam int CLKOUT_SEL_W   = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] PER_RST   = 6'h3f;  // All pads on address function
  localparam logic [5:0] DDR_RST   = 6'h00;  // Port function starts as input
  localparam logic [5:0] DOUT_RST  = 6'h00;
  localparam logic [5:0] PUR_RST   = 6'h00;  // Pull-ups active
  localparam logic       HOLD_RST  = 1'b0;
  localparam logic       PLLREF_RST = 1'b0;

  // Clock output source selection
  typedef enum logic [2:0] {
    CO_OFF    = 3'b000,
    CO_MASTER = 3'b001,
    CO_PBUS   = 3'b010,
    CO_OSC    = 3'b011,
    CO_PRE    = 3'b100,
    CO_POST   = 3'b101
  } clkout_sel_t;

endpackage

// *** hw/clock_and_address_pad_mux.sv ***
// Purpose: Clock strap, clock-output source select and address/port pad muxing.
// Assumes: All inputs synchronous to SYS_CLK; clock sources arrive as sampled levels.
// Notes:   Pad outputs have low-active enables; pull-up enables are high-active.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - Strap 1 selects driven clock on drive pin; 0 selects crystal.
// - Input clock feeds core directly or PLL reference, by setting.
// - Clock out pin source: off, master, bus, osc, prescaler, postscaler.
// - Six pads carry address lines zero to five by default.
// - Address and memory controls tri-state while bus idle, unless drive bit.
// - Each pad in port function is individually input or output.
// - Pull-ups on by default; writing one to matching bit turns off.
// - Pads stay on address function until software selects port function.
// - Every pad starts in primary function; alternates need programming.
// - Switching a pad to port with nothing else changed makes an input.
module clock_and_address_pad_mux (
  // Clock, reset, enable
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST,
  input  wire logic                     CE,
  // APB slave
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [7:0]               PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  // Oscillator strap and clock sources
  input  wire logic                     CLOCK_INPUT_SELECT,
  input  wire logic                     OSC_DRIVE_IN,
  input  wire logic                     OSC_CRYSTAL_OUT,
  input  wire logic                     PLL_OUT_CLK,
  input  wire logic                     PERIPHERAL_BUS_CLK,
  input  wire logic                     PRESCALER_CLK,
  input  wire logic                     POSTSCALER_CLK,
  output logic                          CHIP_INPUT_CLK,
  output logic                          MASTER_SYSTEM_CLK,
  output logic                          PLL_REF_CLK,
  output logic                          CLOCK_OUT_PIN_O,
  output logic                          CLOCK_OUT_PIN_OE_N,
  // External memory interface side
  input  wire logic [5:0]               EXT_MEM_ADDR,
  input  wire logic                     EXT_BUS_ACTIVE,
  output logic                          EXT_MEM_CTRL_OE_N,
  // Shared pads
  input  wire logic [5:0]               PAD_I,
  output logic      [5:0]               PAD_O,
  output logic      [5:0]               PAD_OE_N,
  output logic      [5:0]               PAD_PULLUP_EN
);
  import pad_mux_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  clkout_sel_t      clkout_sel_r;
  logic             drive_hold_r;
  logic             pll_ref_r;
  logic [5:0]       per_r;
  logic [5:0]       ddr_r;
  logic [5:0]       dout_r;
  logic [5:0]       pur_r;
  logic             strap_r;
  logic             strap_taken_r;
  logic             in_clk;
  logic             clkout_nxt;
  logic             wr_en;
  logic             rd_en;
  logic [31:0]      rdata_nxt;
  logic             err_nxt;

  // Place a 6-bit pad field at its port bit positions
  function automatic logic [31:0] port_word(input logic [5:0] f);
    port_word = {18'h00000, f, 8'h00};
  endfunction

  // Pull the 6-bit pad field from a port word
  function automatic logic [5:0] port_field(input logic [31:0] w);
    port_field = w[PAD_LSB +: PAD_N];
  endfunction

  // Single wait-free access: write lands in the access cycle, read data is captured in setup
  assign wr_en = CE && PSEL && PENABLE && PWRITE;
  assign rd_en = CE && PSEL && !PENABLE && !PWRITE;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Strap is caught on the first enabled edge after reset release;
  // later changes are ignored because the pin is meant to be static.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      strap_r       <= 1'b0;
      strap_taken_r <= 1'b0;
    end else if (CE && !strap_taken_r) begin
      strap_r       <= CLOCK_INPUT_SELECT;
      strap_taken_r <= 1'b1;
    end
  end

  // Input clock source per strap, then core or PLL path
  always_comb begin
    in_clk = strap_r ? OSC_DRIVE_IN : OSC_CRYSTAL_OUT;
  end

  // ----------------------------------------------------------------
  // APB register writes
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      clkout_sel_r <= CO_OFF;
      drive_hold_r <= HOLD_RST;
      pll_ref_r    <= PLLREF_RST;
    end else if (wr_en) begin
      case (PADDR)
        OFS_CLKOUT_SEL: begin
          clkout_sel_r <= clkout_sel_t'(PWDATA[CLKOUT_SEL_W-1:0]);
        end
        OFS_BUS_CTRL: begin
          drive_hold_r <= PWDATA[BUS_DRIVE_BIT];
          pll_ref_r    <= PWDATA[PLL_REF_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Port registers; ddr untouched by a per write, so a newly freed pad is input
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      per_r  <= PER_RST;
      ddr_r  <= DDR_RST;
      dout_r <= DOUT_RST;
      pur_r  <= PUR_RST;
    end else if (wr_en) begin
      case (PADDR)
        OFS_PORT_PER:  per_r  <= port_field(PWDATA);
        OFS_PORT_DDR:  ddr_r  <= port_field(PWDATA);
        OFS_PORT_DOUT: dout_r <= port_field(PWDATA);
        OFS_PORT_PUR:  pur_r  <= port_field(PWDATA);
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h00000000;
    err_nxt   = 1'b0;
    case (PADDR)
      OFS_CLKOUT_SEL: rdata_nxt = {29'h00000000, clkout_sel_r};
      OFS_BUS_CTRL:   rdata_nxt = {30'h00000000, pll_ref_r, drive_hold_r};
      OFS_PORT_PER:   rdata_nxt = port_word(per_r);
      OFS_PORT_DDR:   rdata_nxt = port_word(ddr_r);
      OFS_PORT_DOUT:  rdata_nxt = port_word(dout_r);
      OFS_PORT_PUR:   rdata_nxt = port_word(pur_r);
      OFS_PORT_DIN:   rdata_nxt = port_word(PAD_I);
      OFS_STATUS:     rdata_nxt = {30'h00000000, EXT_BUS_ACTIVE, strap_r};
      default:        err_nxt   = 1'b1;
    endcase
  end

  // Data registered in setup so PRDATA is a flop in the access phase
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (rd_en) begin
        PRDATA <= rdata_nxt;
      end
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Clock distribution and clock output
  // ----------------------------------------------------------------
  always_comb begin
    case (clkout_sel_r)
      CO_OFF:    clkout_nxt = 1'b0;
      CO_MASTER: clkout_nxt = pll_ref_r ? PLL_OUT_CLK : in_clk;
      CO_PBUS:   clkout_nxt = PERIPHERAL_BUS_CLK;
      CO_OSC:    clkout_nxt = in_clk;
      CO_PRE:    clkout_nxt = PRESCALER_CLK;
      CO_POST:   clkout_nxt = POSTSCALER_CLK;
      default:   clkout_nxt = 1'b0;
    endcase
  end

  // Sampled clock levels; outputs come from flops, so edges lag one cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CHIP_INPUT_CLK     <= 1'b0;
      MASTER_SYSTEM_CLK  <= 1'b0;
      PLL_REF_CLK        <= 1'b0;
      CLOCK_OUT_PIN_O    <= 1'b0;
      CLOCK_OUT_PIN_OE_N <= 1'b1;
    end else if (CE) begin
      CHIP_INPUT_CLK     <= in_clk;
      MASTER_SYSTEM_CLK  <= pll_ref_r ? PLL_OUT_CLK : in_clk;
      PLL_REF_CLK        <= pll_ref_r ? in_clk : 1'b0;
      CLOCK_OUT_PIN_O    <= clkout_nxt;
      // Codes 6 and 7 name no source, so the pin stays released for them
      CLOCK_OUT_PIN_OE_N <= (clkout_sel_r == CO_OFF) || (clkout_sel_r > CO_POST);
    end
  end

  // ----------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------
  // Address pads drive while bus active or drive-hold set; port pads per ddr
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PAD_O         <= 6'h00;
      PAD_OE_N      <= 6'h3f;
      PAD_PULLUP_EN <= 6'h3f;
      EXT_MEM_CTRL_OE_N <= 1'b1;
    end else if (CE) begin
      for (int i = 0; i < PAD_N; i++) begin
        if (per_r[i]) begin
          PAD_O[i]    <= EXT_MEM_ADDR[i];
          PAD_OE_N[i] <= !(EXT_BUS_ACTIVE || drive_hold_r);
        end else begin
          PAD_O[i]    <= dout_r[i];
          PAD_OE_N[i] <= !ddr_r[i];
        end
      end
      PAD_PULLUP_EN <= ~pur_r;
      EXT_MEM_CTRL_OE_N <= !(EXT_BUS_ACTIVE || drive_hold_r);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_pads_off: assert property (@(posedge SYS_CLK)
    RST |=> (PAD_OE_N == 6'h3f && CLOCK_OUT_PIN_OE_N && PAD_PULLUP_EN == 6'h3f))
    else $error("pads not quiet after reset");

  a_strap_crystal: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && strap_taken_r && !strap_r) |=> (CHIP_INPUT_CLK == $past(OSC_CRYSTAL_OUT)))
    else $error("crystal path not used");

  a_strap_driven: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && strap_taken_r && strap_r) |=> (CHIP_INPUT_CLK == $past(OSC_DRIVE_IN)))
    else $error("driven clock path not used");

  a_pll_ref_path: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && !pll_ref_r) |=> (PLL_REF_CLK == 1'b0))
    else $error("pll reference active when core fed directly");

  a_clkout_disabled: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && clkout_sel_r == CO_OFF) |=> CLOCK_OUT_PIN_OE_N)
    else $error("clock out driven while disabled");

  a_addr_default: assert property (@(posedge SYS_CLK)
    RST |=> per_r == 6'h3f)
    else $error("pads not on address after reset");

  a_idle_tristate: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && per_r[0] && !EXT_BUS_ACTIVE && !drive_hold_r) |=> PAD_OE_N[0])
    else $error("address pad driven on idle bus");

  a_ctrl_idle_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && !EXT_BUS_ACTIVE && !drive_hold_r) |=> EXT_MEM_CTRL_OE_N)
    else $error("memory control driven on idle bus");

  a_drive_hold_on: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && per_r[5] && drive_hold_r) |=> !PAD_OE_N[5])
    else $error("address pad released while drive hold set");

  a_addr_drive: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && per_r[3] && EXT_BUS_ACTIVE) |=> (!PAD_OE_N[3] && PAD_O[3] == $past(EXT_MEM_ADDR[3])))
    else $error("address line not on its pad");

  a_clkout_reserved: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && clkout_sel_r > CO_POST) |=> CLOCK_OUT_PIN_OE_N)
    else $error("clock out driven for unused select code");

  a_per_keeps_ddr: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_en && PADDR == OFS_PORT_PER) |=> (ddr_r == $past(ddr_r)))
    else $error("direction changed by function select write");

  a_port_input: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CE && !per_r[1] && !ddr_r[1]) |=> PAD_OE_N[1])
    else $error("port pad driven while input");

  a_pullup_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_en && PADDR == OFS_PORT_PUR && PWDATA[PAD_LSB]) ##1 CE |=> !PAD_PULLUP_EN[0])
    else $error("pull-up not turned off");

  c_port_output: cover property (@(posedge SYS_CLK) !per_r[2] && ddr_r[2] && !PAD_OE_N[2]);
  c_clkout_post: cover property (@(posedge SYS_CLK) clkout_sel_r == CO_POST);
  c_pll_ref:     cover property (@(posedge SYS_CLK) pll_ref_r && strap_r);
  // Crystal path only shows up after a reset with the strap low
  c_crystal:     cover property (@(posedge SYS_CLK) strap_taken_r && !strap_r);
endmodule

// *** test/ext_board_model.sv ***
// Purpose: Board model: clock source on the drive pin or crystal side, per strap, and pad wires.
// Assumes: Strap high means a driven clock with the sense pin grounded.
// Notes:   Unpulled released pads toggle so a stale level never passes.
`timescale 1ns/1ps
module ext_board_model (
  // Clock and strap
  input  wire logic       clk,
  input  wire logic       strap,
  input  wire logic       osc_lvl,
  output logic            drive_pin,
  output logic            crystal_out,
  // Pad wires
  input  wire logic [5:0] pad_o,
  input  wire logic [5:0] pad_oe_n,
  input  wire logic [5:0] pull_en,
  input  wire logic [5:0] ext_oe,
  input  wire logic [5:0] ext_val,
  output logic      [5:0] pad_i
);
  logic flt_r = 1'b0;

  // Level seen on a released wire with no pull-up
  always_ff @(posedge clk) begin
    flt_r <= ~flt_r;
  end

  // Strap high grounds the sense pin, so the crystal side stays low; strap low puts the clock on the crystal side
  assign drive_pin   = strap ? osc_lvl : flt_r;
  assign crystal_out = strap ? 1'b0 : osc_lvl;

  // Wire level resolved from every party's enable
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pad_oe_n[i]) pad_i[i] = pad_o[i];
      else if (ext_oe[i]) pad_i[i] = ext_val[i];
      else if (pull_en[i]) pad_i[i] = 1'b1;
      else pad_i[i] = flt_r;
    end
  end
endmodule

// *** test/clock_and_address_pad_mux_bench.sv ***
// Purpose: Self-checking bench for the clock and address pad mux.
// Assumes: APB slave answers in the access phase; CE low freezes state.
// Notes:   Pad outputs are sampled on the falling edge after settling.
`timescale 1ns/1ps
module clock_and_address_pad_mux_bench;
  import pad_mux_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, strap, osc_lvl;
  logic        drive_lvl, crystal, pll, pbus, pre, post, chip_clk, mst_clk, ref_clk;
  logic        co, co_oe_n, bus_act, ctrl_oe_n, er, ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  mem_addr, pad_i, pad_o, pad_oe_n, pull_en, ext_oe, ext_val;
  logic [4:0]  src, oh;
  int          fails, samples_checked, cyc;

  assign {post, pre, pbus, pll, osc_lvl} = src;

  clock_and_address_pad_mux i_clock_and_address_pad_mux (
    .SYS_CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CLOCK_INPUT_SELECT(strap),
    .OSC_DRIVE_IN(drive_lvl), .OSC_CRYSTAL_OUT(crystal), .PLL_OUT_CLK(pll),
    .PERIPHERAL_BUS_CLK(pbus), .PRESCALER_CLK(pre), .POSTSCALER_CLK(post),
    .CHIP_INPUT_CLK(chip_clk), .MASTER_SYSTEM_CLK(mst_clk), .PLL_REF_CLK(ref_clk),
    .CLOCK_OUT_PIN_O(co), .CLOCK_OUT_PIN_OE_N(co_oe_n), .EXT_MEM_ADDR(mem_addr),
    .EXT_BUS_ACTIVE(bus_act), .EXT_MEM_CTRL_OE_N(ctrl_oe_n), .PAD_I(pad_i),
    .PAD_O(pad_o), .PAD_OE_N(pad_oe_n), .PAD_PULLUP_EN(pull_en));

  ext_board_model i_ext_board_model (
    .clk(clk), .strap(strap), .osc_lvl(osc_lvl), .drive_pin(drive_lvl),
    .crystal_out(crystal), .pad_o(pad_o), .pad_oe_n(pad_oe_n), .pull_en(pull_en),
    .ext_oe(ext_oe), .ext_val(ext_val), .pad_i(pad_i));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; holds the request until PREADY is seen high.
  // Only the bench timeout ends a wait that never sees an answer.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
    chk(er, 1'b0, "slverr");
  endtask

  // Pad outputs lag their registers by one cycle
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic reset_state();
    chk(pad_oe_n, 6'h3f, "rst pad oe");
    chk(co_oe_n, 1'b1, "rst clkout oe");
    chk(pull_en, 6'h3f, "rst pullup");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, strap, bus_act} = 6'b100010;
    {paddr, pwdata, src, ext_oe, ext_val} = '0;
    ce = 1'b1;
    mem_addr = 6'h2d;
    repeat (19) @(posedge clk);
    @(negedge clk);
    reset_state();
    @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_PORT_PER, 32'h3f00, "per rst");
    rd_chk(OFS_PORT_DDR, 32'h0, "ddr rst");
    rd_chk(OFS_PORT_PUR, 32'h0, "pur rst");
    rd_chk(OFS_STATUS, 32'h1, "strap");
    settle();
    chk({ctrl_oe_n, pad_oe_n}, 7'h7f, "idle tristate");
    // Enable low: bus activity must not reach the frozen pad flops
    @(posedge clk);
    ce <= 1'b0;
    bus_act <= 1'b1;
    settle();
    chk(pad_oe_n, 6'h3f, "frozen pads");
    @(posedge clk);
    ce <= 1'b1;
    settle();
    chk({pad_oe_n, pad_o}, 12'h02d, "addr drive");
    @(posedge clk);
    bus_act <= 1'b0;
    apb(1'b1, OFS_BUS_CTRL, 32'h1);
    settle();
    chk({ctrl_oe_n, pad_oe_n, pad_o}, 13'h002d, "drive hold");
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, OFS_BUS_CTRL, 32'(1 + 2 * p));
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        src <= k ? 5'h02 : 5'h01;
        settle();
        chk(chip_clk, !k, "input clock");
        chk(ref_clk, p ? !k : 1'b0, "pll ref");
        chk(mst_clk, p ? k : !k, "master");
      end
    end
    apb(1'b1, OFS_BUS_CTRL, 32'h1);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, OFS_CLKOUT_SEL, 32'(s));
      oh = (s == 1 || s == 3) ? 5'h01 : (s == 2) ? 5'h04 : (s == 4) ? 5'h08 :
           (s == 5) ? 5'h10 : 5'h00;
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        src <= k ? ~oh : oh;
        settle();
        chk(co_oe_n, (s > 0 && s < 6) ? 1'b0 : 1'b1, "clkout oe");
        if (oh != 5'h00) chk(co, !k, "clkout src");
      end
    end
    @(posedge clk);
    ext_oe <= 6'h3f;
    ext_val <= 6'h13;
    apb(1'b1, OFS_PORT_PER, 32'h0);
    settle();
    chk(pad_oe_n, 6'h3f, "port input");
    rd_chk(OFS_PORT_DIN, 32'h1300, "pad in");
    ext_oe <= 6'h15;
    apb(1'b1, OFS_PORT_DDR, 32'h2a00);
    apb(1'b1, OFS_PORT_DOUT, 32'h3c00);
    settle();
    chk({pad_oe_n, pad_o & 6'h2a}, 12'h568, "port mixed");
    rd_chk(OFS_PORT_DIN, 32'h3900, "pad mixed");
    apb(1'b1, OFS_PORT_PUR, 32'h0500);
    settle();
    chk(pull_en, 6'h3a, "pullup off");
    @(posedge clk);
    ext_oe <= 6'h0;
    apb(1'b1, OFS_PORT_PER, 32'h3f00);
    settle();
    chk({pad_oe_n, pad_o}, 12'h02d, "addr again");
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    chk(er, 1'b1, "unmapped error");
    // Second reset, released with the strap low to use the crystal path
    rst <= 1'b1;
    strap <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    reset_state();
    @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_STATUS, 32'h0, "strap low");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      src <= k ? 5'h01 : 5'h00;
      settle();
      chk(chip_clk, k, "crystal clock");
    end
    report_and_stop();
  end
endmodule
